// ---- common/sink_driver_pkg.sv ----
// Purpose: shared constants for the serial-in latched sink driver
// Assumes: one core clock at 100 MHz, all device pins sampled on it
// Notes:   widths and depths are fixed

package sink_driver_pkg;

  // ****************************************
  // widths and depths
  // ****************************************
  localparam int STAGE_COUNT = 8;
  localparam int FIFO_DEPTH  = 8;
  localparam int SYNC_DEPTH  = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [STAGE_COUNT-1:0] STAGES_RESET = 8'h00;
  localparam logic [STAGE_COUNT-1:0] SINK_OFF     = 8'h00;
  localparam logic [SYNC_DEPTH-1:0]  SYNC_LOW     = 2'h0;
  localparam logic [SYNC_DEPTH-1:0]  SYNC_HIGH    = 2'h3;
  localparam logic                   SERIAL_RESET = 1'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CORE_CLK_MHZ        = 100;
  localparam int SHIFT_CLK_MAX_MHZ   = 10;
  localparam int SHIFT_MIN_PERIOD_CYC = CORE_CLK_MHZ / SHIFT_CLK_MAX_MHZ;

  typedef logic [STAGE_COUNT-1:0] stages_type;

endpackage : sink_driver_pkg

// ---- common/word_stream_if.sv ----
// Purpose: valid/ready word stream between the driver and its fifo
// Assumes: single clock domain
// Notes:   word moves when valid and ready are both high
`timescale 1ns/100ps

interface word_stream_if;
  import sink_driver_pkg::*;

  logic       pushValid;
  logic       pushReady;
  stages_type pushData;
  logic       popValid;
  logic       popReady;
  stages_type popData;
  logic       flush;

  modport owner (
    output pushValid,
    input  pushReady,
    output pushData,
    input  popValid,
    output popReady,
    input  popData,
    output flush
  );

  modport buffer (
    input  pushValid,
    output pushReady,
    input  pushData,
    output popValid,
    input  popReady,
    output popData,
    input  flush
  );

endinterface : word_stream_if

// ---- logic/word_fifo.sv ----
// Purpose: small fifo holding latched words on their way to storage
// Assumes: flush empties it in one cycle
// Notes:   head word is held in a register; total capacity DEPTH + 1
`timescale 1ns/100ps

module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic    core_clk,
  input wire logic    rst_b,
  word_stream_if.buffer port
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_q;
  logic [PTR_W-1:0] rdPtr_q;
  logic [PTR_W:0]   count_q;
  logic [WIDTH-1:0] head_q;
  logic             headValid_q;

  wire memFull  = (count_q == (PTR_W+1)'(DEPTH));
  wire memEmpty = (count_q == '0);
  wire doPush   = port.pushValid && !memFull;
  wire doLoad   = !memEmpty && (!headValid_q || port.popReady);
  wire doDrop   = headValid_q && port.popReady && memEmpty;

  assign port.pushReady = !memFull;
  assign port.popValid  = headValid_q;
  assign port.popData   = head_q;

  // ****************************************
  // storage array
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem[wrPtr_q] <= port.pushData[WIDTH-1:0];
    end
  end

  // ****************************************
  // pointers and head register
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q     <= '0;
      rdPtr_q     <= '0;
      count_q     <= '0;
      head_q      <= '0;
      headValid_q <= 1'b0;
    end else if (port.flush) begin
      wrPtr_q     <= '0;
      rdPtr_q     <= '0;
      count_q     <= '0;
      head_q      <= '0;
      headValid_q <= 1'b0;
    end else begin
      if (doPush) begin
        wrPtr_q <= (wrPtr_q == PTR_W'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (doLoad) begin
        rdPtr_q     <= (rdPtr_q == PTR_W'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
        head_q      <= mem[rdPtr_q];
        headValid_q <= 1'b1;
      end else if (doDrop) begin
        headValid_q <= 1'b0;
      end
      count_q <= count_q + (PTR_W+1)'(doPush) - (PTR_W+1)'(doLoad);
    end
  end

endmodule : word_fifo

// ---- logic/serial_sink_driver.sv ----
// Purpose: serial-in shift register, storage latch and eight gated sink outputs
// Assumes: all pins are asynchronous to core_clk and pass two flip-flops
// Notes:   pin edges are seen two to three core cycles late
`timescale 1ns/100ps

// What this block does
// - eight-stage shift register takes serial_in on each shift_clock rise
// - latch_clock rise captures all eight stages; storage takes them once latch_clock is low again
// - clear_n low forces shift stages and storage to zero
// - storage reaches outputs only while clear_n high; cleared data otherwise
// - output enable high holds all sink outputs off
// - output enable low lets outputs follow storage without further clocking
// - sink bit one sinks current, zero is off
// - serial_out updates on shift_clock falling edge
module serial_sink_driver (
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire logic                    shift_clock,
  input  wire logic                    latch_clock,
  input  wire logic                    clear_n,
  input  wire logic                    serial_in,
  input  wire logic                    outEnable_n,
  output logic                         serial_out,
  output sink_driver_pkg::stages_type  sinkOutput,
  output logic                         latchReady
);
  import sink_driver_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [SYNC_DEPTH-1:0] shiftSync_q;
  logic [SYNC_DEPTH-1:0] latchSync_q;
  logic [SYNC_DEPTH-1:0] clearSync_q;
  logic [SYNC_DEPTH-1:0] dataSync_q;
  logic [SYNC_DEPTH-1:0] oeSync_q;
  logic                  shiftPrev_q;
  logic                  latchPrev_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shiftSync_q <= SYNC_LOW;
      latchSync_q <= SYNC_LOW;
      clearSync_q <= SYNC_LOW;
      dataSync_q  <= SYNC_LOW;
      oeSync_q    <= SYNC_HIGH;
      shiftPrev_q <= 1'b0;
      latchPrev_q <= 1'b0;
    end else begin
      shiftSync_q <= {shiftSync_q[0], shift_clock};
      latchSync_q <= {latchSync_q[0], latch_clock};
      clearSync_q <= {clearSync_q[0], clear_n};
      dataSync_q  <= {dataSync_q[0], serial_in};
      oeSync_q    <= {oeSync_q[0], outEnable_n};
      shiftPrev_q <= shiftSync_q[1];
      latchPrev_q <= latchSync_q[1];
    end
  end

  wire shiftLvl  = shiftSync_q[1];
  wire latchLvl  = latchSync_q[1];
  wire clearLvl  = clearSync_q[1];
  wire dataLvl   = dataSync_q[1];
  wire oeOffLvl  = oeSync_q[1];
  wire shiftRise = shiftLvl && !shiftPrev_q;
  wire shiftFall = !shiftLvl && shiftPrev_q;
  wire latchRise = latchLvl && !latchPrev_q;

  // ****************************************
  // shift register
  // ****************************************
  stages_type shiftReg_q;
  stages_type shiftReg_d;

  assign shiftReg_d = {shiftReg_q[STAGE_COUNT-2:0], dataLvl};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shiftReg_q <= STAGES_RESET;
    end else if (!clearLvl) begin
      shiftReg_q <= STAGES_RESET;
    end else if (shiftRise) begin
      shiftReg_q <= shiftReg_d;
    end
  end

  // ****************************************
  // serial output on falling edge
  // ****************************************
  logic serialOut_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      serialOut_q <= SERIAL_RESET;
    end else if (!clearLvl) begin
      serialOut_q <= SERIAL_RESET;
    end else if (shiftFall) begin
      serialOut_q <= shiftReg_q[STAGE_COUNT-1];
    end
  end

  assign serial_out = serialOut_q;

  // ****************************************
  // latch path through fifo
  // ****************************************
  word_stream_if stream ();

  assign stream.pushValid = latchRise && clearLvl;
  assign stream.pushData  = shiftReg_q;
  assign stream.popReady  = !latchLvl;
  assign stream.flush     = !clearLvl;

  word_fifo #(
    .WIDTH (STAGE_COUNT),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .port     (stream)
  );

  logic latchReady_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      latchReady_q <= 1'b0;
    end else begin
      latchReady_q <= stream.pushReady;
    end
  end

  assign latchReady = latchReady_q;

  // ****************************************
  // storage register
  // ****************************************
  stages_type storage_q;
  wire        storeWord = stream.popValid && stream.popReady;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      storage_q <= STAGES_RESET;
    end else if (!clearLvl) begin
      storage_q <= STAGES_RESET;
    end else if (storeWord) begin
      storage_q <= stream.popData;
    end
  end

  // ****************************************
  // output buffer and sinks
  // ****************************************
  stages_type sink_q;
  stages_type sink_d;
  stages_type bufferData;

  assign bufferData = clearLvl ? storage_q : STAGES_RESET;
  assign sink_d     = oeOffLvl ? SINK_OFF : bufferData;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sink_q <= SINK_OFF;
    end else begin
      sink_q <= sink_d;
    end
  end

  assign sinkOutput = sink_q;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_shiftTaken;
    shiftRise && clearLvl;
  endsequence

  property p_shiftAdvance;
    @(posedge core_clk) disable iff (!rst_b)
    s_shiftTaken |=> shiftReg_q == {$past(shiftReg_q[6:0]), $past(dataLvl)};
  endproperty
  a_shiftAdvance: assert property (p_shiftAdvance)
    else $error("shift register did not advance on shift edge");

  property p_shiftHold;
    @(posedge core_clk) disable iff (!rst_b)
    (!shiftRise && clearLvl) |=> $stable(shiftReg_q);
  endproperty
  a_shiftHold: assert property (p_shiftHold)
    else $error("shift register moved without a shift edge");

  sequence s_latchTaken;
    latchRise && clearLvl && !stream.popValid && u_fifo.memEmpty ##1 clearLvl;
  endsequence

  property p_latchPush;
    @(posedge core_clk) disable iff (!rst_b)
    s_latchTaken |=> stream.popValid && stream.popData == $past(shiftReg_q, 2);
  endproperty
  a_latchPush: assert property (p_latchPush)
    else $error("latch edge did not capture shift stages");

  property p_storeOnlyLow;
    @(posedge core_clk) disable iff (!rst_b)
    (clearLvl && $past(clearLvl) && $changed(storage_q)) |-> !$past(latchLvl);
  endproperty
  a_storeOnlyLow: assert property (p_storeOnlyLow)
    else $error("storage changed while latch clock high");

  property p_clearAll;
    @(posedge core_clk) disable iff (!rst_b)
    !clearLvl |=> shiftReg_q == STAGES_RESET && storage_q == STAGES_RESET;
  endproperty
  a_clearAll: assert property (p_clearAll)
    else $error("clear did not zero registers");

  sequence s_clearHeld;
    !clearLvl [*2];
  endsequence

  property p_clearOutputs;
    @(posedge core_clk) disable iff (!rst_b)
    s_clearHeld |-> sink_q == SINK_OFF;
  endproperty
  a_clearOutputs: assert property (p_clearOutputs)
    else $error("outputs not cleared during clear");

  property p_oeOff;
    @(posedge core_clk) disable iff (!rst_b)
    oeOffLvl |=> sink_q == SINK_OFF;
  endproperty
  a_oeOff: assert property (p_oeOff)
    else $error("outputs on while enable high");

  property p_oeFollow;
    @(posedge core_clk) disable iff (!rst_b)
    (!oeOffLvl && clearLvl) |=> sink_q == $past(storage_q);
  endproperty
  a_oeFollow: assert property (p_oeFollow)
    else $error("outputs do not follow storage");

  property p_serialFall;
    @(posedge core_clk) disable iff (!rst_b)
    (shiftFall && clearLvl) |=> serialOut_q == $past(shiftReg_q[7]);
  endproperty
  a_serialFall: assert property (p_serialFall)
    else $error("serial out not updated on falling edge");

  property p_serialStill;
    @(posedge core_clk) disable iff (!rst_b)
    (!shiftFall && clearLvl) |=> $stable(serialOut_q);
  endproperty
  a_serialStill: assert property (p_serialStill)
    else $error("serial out changed without falling edge");

endmodule : serial_sink_driver

// ---- test/sink_host_model.sv ----
// Purpose: host that drives the driver's pins
// Assumes: pins change just after a core_clk rise
// Notes:   shift clock period is 16 core cycles
`timescale 1ns/100ps

module sink_host_model (
  input  wire logic core_clk,
  output logic      shift_clock,
  output logic      latch_clock,
  output logic      clear_n,
  output logic      serial_in,
  output logic      outEnable_n
);
  // ****************************************
  // pin start values
  // ****************************************
  initial begin
    shift_clock = 1'b0;
    latch_clock = 1'b0;
    clear_n     = 1'b0;
    serial_in   = 1'b0;
    outEnable_n = 1'b1;
  end

  // ****************************************
  // pin tasks
  // ****************************************
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask : hold

  // data set up four core cycles before the rise
  task automatic shift_rise(input logic b);
    @(posedge core_clk);
    serial_in <= b;
    hold(4);
    shift_clock <= 1'b1;
    hold(5);
  endtask : shift_rise

  task automatic shift_fall();
    @(posedge core_clk);
    shift_clock <= 1'b0;
    hold(5);
  endtask : shift_fall

  // data trusted only once latch is low again
  task automatic latch_pulse();
    @(posedge core_clk);
    latch_clock <= 1'b1;
    hold(5);
    latch_clock <= 1'b0;
    hold(12);
  endtask : latch_pulse

  task automatic set_enable_n(input logic v);
    @(posedge core_clk);
    outEnable_n <= v;
    hold(8);
  endtask : set_enable_n

  task automatic set_clear_n(input logic v);
    @(posedge core_clk);
    clear_n <= v;
    hold(8);
  endtask : set_clear_n
endmodule : sink_host_model

// ---- test/tb_top.sv ----
// Purpose: self-checking bench for the sink driver
// Assumes: host model drives all pins
// Notes:   expected shift state kept in expStage
`timescale 1ns/100ps

`define CHECK(got, exp) begin nCompared++; if ((got) !== (exp)) begin errCount++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_top;
  import sink_driver_pkg::*;

  logic       core_clk;
  logic       rst_b;
  logic       shift_clock;
  logic       latch_clock;
  logic       clear_n;
  logic       serial_in;
  logic       outEnable_n;
  logic       serial_out;
  stages_type sinkOutput;
  logic       latchReady;
  stages_type expStage;
  int         errCount;
  int         nCompared;

  // ****************************************
  // clock, reset, instances
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  sink_host_model host_u (
    .core_clk    (core_clk),
    .shift_clock (shift_clock),
    .latch_clock (latch_clock),
    .clear_n     (clear_n),
    .serial_in   (serial_in),
    .outEnable_n (outEnable_n)
  );

  serial_sink_driver dut_u (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .shift_clock (shift_clock),
    .latch_clock (latch_clock),
    .clear_n     (clear_n),
    .serial_in   (serial_in),
    .outEnable_n (outEnable_n),
    .serial_out  (serial_out),
    .sinkOutput  (sinkOutput),
    .latchReady  (latchReady)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // msb first, checks serial_out around each edge
  task automatic send_byte(input stages_type v);
    logic prev;
    for (int i = 7; i >= 0; i--) begin
      prev = expStage[7];
      host_u.shift_rise(v[i]);
      #1;
      expStage = {expStage[6:0], v[i]};
      `CHECK(serial_out, prev)
      host_u.shift_fall();
      #1;
      `CHECK(serial_out, expStage[7])
    end
  endtask : send_byte

  // ****************************************
  // scenarios
  // ****************************************
  task automatic scen_reset();
    host_u.set_clear_n(1'b1);
    #1;
    `CHECK(sinkOutput, SINK_OFF)
    `CHECK(serial_out, 1'b0)
    `CHECK(latchReady, 1'b1)
  endtask : scen_reset

  task automatic scen_load();
    host_u.set_enable_n(1'b0);
    send_byte(8'hA5);
    host_u.latch_pulse();
    #1;
    `CHECK(sinkOutput, 8'hA5)
    send_byte(8'hC3);
    #1;
    `CHECK(sinkOutput, 8'hA5)
    host_u.latch_pulse();
    #1;
    `CHECK(sinkOutput, 8'hC3)
  endtask : scen_load

  task automatic scen_enable();
    for (int k = 0; k < 3; k++) begin
      host_u.set_enable_n(1'b1);
      #1;
      `CHECK(sinkOutput, SINK_OFF)
      host_u.set_enable_n(1'b0);
      #1;
      `CHECK(sinkOutput, 8'hC3)
    end
  endtask : scen_enable

  task automatic scen_clear();
    host_u.set_clear_n(1'b0);
    #1;
    `CHECK(sinkOutput, SINK_OFF)
    `CHECK(serial_out, 1'b0)
    host_u.set_clear_n(1'b1);
    expStage = STAGES_RESET;
    host_u.latch_pulse();
    #1;
    `CHECK(sinkOutput, SINK_OFF)
    send_byte(8'h81);
    host_u.latch_pulse();
    #1;
    `CHECK(sinkOutput, 8'h81)
  endtask : scen_clear

  // reset in mid-run, then a fresh load
  task automatic scen_midreset();
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    `CHECK(sinkOutput, SINK_OFF)
    `CHECK(serial_out, SERIAL_RESET)
    `CHECK(latchReady, 1'b0)
    @(posedge core_clk);
    rst_b <= 1'b1;
    expStage = STAGES_RESET;
    repeat (4) @(posedge core_clk);
    #1;
    `CHECK(latchReady, 1'b1)
    `CHECK(sinkOutput, SINK_OFF)
    send_byte(8'h5A);
    host_u.latch_pulse();
    #1;
    `CHECK(sinkOutput, 8'h5A)
  endtask : scen_midreset

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    rst_b     = 1'b0;
    errCount  = 0;
    nCompared = 0;
    expStage  = STAGES_RESET;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    scen_reset();
    scen_load();
    scen_enable();
    scen_clear();
    scen_midreset();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errCount++;
    give_verdict();
  end
endmodule : tb_top
